//--- logic/aisf_pkg.sv
// Constants, types and timing figures for the analog input post-processing block.
// Assumes a single 10 MHz system clock; this package depends on nothing else.
//
// Function
// - Unipolar standard scale runs 0 to 10000.
// - Bipolar standard scale runs -10000 to +10000.
// - User limits clamped to -30000..+30000.
// - User map: standard 0 to low, 10000 to high.
// - Alignment offset added to later measurements.
// - Offset readable, writable; aligned flag per channel.
// - Fast cycle disables filtering.
// - Recalibration uses channel 0 for all.
// - Recalibration sets faults, suspends filter, alignment.
// - Other channels hold pre-recalibration value.
// - 10 V and 5 V references pick range groups.
// - Channel 0 reads 10000 within 10 after.
// - New coefficients take effect only on save.
// - Factory restore reinstates factory coefficients immediately.
// - Leaving unsaved discards new coefficients.
// - Overshoot sets fault, status bit 1, lamp steady.
// - Self-test failure: zeros, lamp; internal fault on reference failure.
// - Only reference test failure reported to processor.
// - Communication failure freezes channel values.
// - Absent connector: fault, bit 2, lamp flashing.
// - Overshoot with connector fault: lamp steady.
// - Overshoot beyond 5 percent, or negative on 0-5 V and 0-20 mA.
package aisf_pkg;
  // ==========================================================================
  // Scaling figures.
  // ==========================================================================
  localparam int STD_FULL = 10000;
  localparam int USER_LIMIT = 30000;
  localparam int ALIGN_LIMIT = 1000;
  localparam int CAL_TOL = 10;
  // Overshoot margin as a percentage of standard full scale.
  localparam int OVER_PCT = 5;
  // Raw codes are signed 16-bit counts in standard-scale units before gain.
  localparam int RAW_W = 16;
  localparam int VAL_W = 16;
  localparam int GAIN_W = 16;
  // Unity gain in Q2.14 fixed point.
  localparam logic [GAIN_W-1:0] GAIN_ONE = 16'h4000;
  localparam int GAIN_FRAC = 14;
  // ==========================================================================
  // Range encodings and status bit positions.
  // ==========================================================================
  localparam logic [2:0] RANGE_PM10V = 3'h0;
  localparam logic [2:0] RANGE_0_10V = 3'h1;
  localparam logic [2:0] RANGE_0_5V = 3'h2;
  localparam logic [2:0] RANGE_1_5V = 3'h3;
  localparam logic [2:0] RANGE_0_20MA = 3'h4;
  localparam logic [2:0] RANGE_4_20MA = 3'h5;
  localparam int STATUS_OVERSHOOT_POS = 1;
  localparam int STATUS_TERMINAL_POS = 2;
  localparam int STATUS_W = 4;
  // ==========================================================================
  // Lamp flashing timing.
  // ==========================================================================
  localparam int CLK_HZ = 10000000;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
  // Calibration sequencer states, Gray coded on the way from idle to captured.
  typedef enum logic [1:0] {
    AISF_CAL_IDLE = 2'b00,
    AISF_CAL_ACTIVE = 2'b01,
    AISF_CAL_CAPTURED = 2'b11
  } aisf_cal_t;
endpackage

//--- logic/aisf_scale.sv
// Per-channel scaling stage: standard or user format, alignment and overshoot check.
// Assumes its inputs are stable for the cycle; purely combinational.
`timescale 1ns/1ns
module aisf_scale
  import aisf_pkg::*;
(
  input wire logic signed [RAW_W-1:0] raw,
  input wire logic [2:0] range_sel,
  input wire logic [GAIN_W-1:0] gain,
  input wire logic user_fmt,
  input wire logic signed [VAL_W-1:0] user_low,
  input wire logic signed [VAL_W-1:0] user_high,
  input wire logic signed [VAL_W-1:0] align_offset,
  input wire logic align_enable,
  output logic signed [VAL_W-1:0] value,
  output logic overshoot
);
  // ==========================================================================
  // Scaling arithmetic.
  // ==========================================================================
  // Clamps a user limit into the legal window.
  function automatic logic signed [VAL_W-1:0] clamp_user(input logic signed [VAL_W-1:0] v);
    if (v > USER_LIMIT) begin
      clamp_user = 16'sh7530;
    end else if (v < -USER_LIMIT) begin
      clamp_user = -16'sh7530;
    end else begin
      clamp_user = v;
    end
  endfunction

  logic signed [33:0] gained; // Raw times calibration gain.
  logic signed [19:0] std_val; // Standard-scale value after alignment.
  logic signed [19:0] lo; // Clamped user low limit.
  logic signed [19:0] hi; // Clamped user high limit.
  logic signed [39:0] prod; // Span times standard value.
  logic signed [39:0] rounded; // Product moved half a step away from zero for rounding.
  logic signed [19:0] mapped; // Final value before saturation.
  logic signed [19:0] bipolar_min; // Lower tolerated bound of the range.

  // Combines gain, alignment, format mapping and range check in one pass.
  always_comb begin
    gained = raw * $signed({1'b0, gain});
    std_val = 20'(gained >>> GAIN_FRAC);
    if (align_enable) begin
      std_val = std_val + 20'(align_offset);
    end
    lo = 20'(clamp_user(user_low));
    hi = 20'(clamp_user(user_high));
    // Overshoot: beyond 5 percent of full scale, or negative on the 0-5 V and 0-20 mA ranges.
    if (range_sel == RANGE_PM10V) begin
      bipolar_min = -20'(STD_FULL + STD_FULL * OVER_PCT / 100);
    end else if (range_sel == RANGE_0_5V || range_sel == RANGE_0_20MA) begin
      bipolar_min = 20'sh0;
    end else begin
      bipolar_min = -20'(STD_FULL * OVER_PCT / 100);
    end
    overshoot = (std_val > 20'(STD_FULL + STD_FULL * OVER_PCT / 100)) ||
                (std_val < bipolar_min);
    prod = 40'(hi - lo) * 40'(std_val);
    // Round half away from zero so both signs stay symmetric.
    if (prod < 0) begin
      rounded = prod - 40'(STD_FULL / 2);
    end else begin
      rounded = prod + 40'(STD_FULL / 2);
    end
    if (user_fmt) begin
      mapped = lo + 20'(rounded / 40'(STD_FULL));
    end else begin
      mapped = std_val;
    end
    // Saturate to the carrier width so a wild input cannot wrap.
    if (mapped > 20'sh07FFF) begin
      value = 16'sh7FFF;
    end else if (mapped < -20'sh08000) begin
      value = -16'sh8000;
    end else begin
      value = VAL_W'(mapped);
    end
  end
endmodule

//--- logic/aisf_top.sv
// Post-conversion processing for a multi-channel analog input module.
// Assumes raw codes arrive on the system clock with a one-cycle valid strobe;
// the connector strap is an asynchronous pin and is synchronised here.
`timescale 1ns/1ns
module aisf_top
  import aisf_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int FLASH_CYC = FLASH_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [$clog2(CHANNELS)-1:0] sample_chan,
  input wire logic signed [RAW_W-1:0] sample_raw,
  input wire logic sample_valid,
  input wire logic [3*CHANNELS-1:0] range_sel,
  input wire logic [CHANNELS-1:0] chan_used,
  input wire logic user_fmt,
  input wire logic signed [VAL_W-1:0] user_low,
  input wire logic signed [VAL_W-1:0] user_high,
  input wire logic fast_cycle,
  input wire logic filter_request,
  input wire logic [$clog2(CHANNELS)-1:0] align_chan,
  input wire logic signed [VAL_W-1:0] align_wdata,
  input wire logic align_write,
  input wire logic align_clear,
  input wire logic recal_enter,
  input wire logic recal_exit,
  input wire logic recal_ref_10v,
  input wire logic recal_ref_5v,
  input wire logic recal_save,
  input wire logic factory_restore,
  input wire logic terminal_monitor_en,
  input wire logic connector_presence_strap,
  input wire logic selftest_ref_fail,
  input wire logic selftest_other_fail,
  input wire logic comm_fail,
  output logic [VAL_W*CHANNELS-1:0] chan_value,
  output logic [CHANNELS-1:0] chan_fault,
  output logic [STATUS_W*CHANNELS-1:0] chan_status,
  output logic [CHANNELS-1:0] chan_aligned,
  output logic signed [VAL_W-1:0] align_rdata,
  output logic internal_fault,
  output logic filter_active,
  output logic recal_active,
  output logic lamp_run,
  output logic lamp_err,
  output logic lamp_io
);
  // ==========================================================================
  // State.
  // ==========================================================================
  localparam int CW = $clog2(CHANNELS);
  localparam int FW = $clog2(FLASH_CYC + 1);

  typedef struct packed {
    logic [2:0] strap_sync; // Three-stage connector strap synchroniser.
    logic strap_present; // Debounced connector presence.
    aisf_cal_t cal_state; // Recalibration sequencer.
    logic [1:0][GAIN_W-1:0] gain_active; // Gains in effect, 10 V and 5 V groups.
    logic [1:0][GAIN_W-1:0] gain_saved; // Last committed user gains.
    logic [1:0][GAIN_W-1:0] gain_new; // Gains captured during recalibration.
    logic [CHANNELS-1:0][VAL_W-1:0] value; // Presented channel values.
    logic [CHANNELS-1:0][VAL_W-1:0] offset; // Alignment offsets.
    logic [CHANNELS-1:0] aligned; // Alignment in effect.
    logic [CHANNELS-1:0] over; // Latest overshoot per channel.
    logic [FW-1:0] flash_cnt; // Flash half-period counter.
    logic flash; // Flash phase.
    logic [VAL_W-1:0] align_rd; // Registered offset read-back.
  } aisf_state_t;

  aisf_state_t st; // Registered state.
  aisf_state_t next_st; // Next state.

  logic signed [VAL_W-1:0] scaled; // Scaled value for the sampled channel.
  logic scaled_over; // Overshoot for the sampled channel.
  logic grp5; // Sampled channel uses the 5 V gain group.
  logic [2:0] cur_range; // Range of the sampled channel.
  logic signed [VAL_W-1:0] ch0_std; // Unity-gain channel 0 reading.
  logic [GAIN_W-1:0] cal_gain; // Gain that brings channel 0 to full scale.
  logic terminal_fault; // Connector missing while monitored.
  logic any_over; // Any channel in overshoot.

  // Picks the gain group for a range code; used for sampling, while recalibration picks it from the reference input.
  function automatic logic range_is_5v(input logic [2:0] r);
    range_is_5v = !(r == RANGE_PM10V || r == RANGE_0_10V);
  endfunction

  assign cur_range = range_sel[3*sample_chan +: 3];
  assign grp5 = range_is_5v(cur_range);
  assign ch0_std = sample_raw;

  // ==========================================================================
  // Scaling datapath, shared across channels.
  // ==========================================================================
  aisf_scale u_scale (
    .raw(sample_raw),
    .range_sel(cur_range),
    .gain(st.gain_active[grp5]),
    .user_fmt(user_fmt),
    .user_low(user_low),
    .user_high(user_high),
    .align_offset(st.offset[sample_chan]),
    .align_enable(st.aligned[sample_chan] && st.cal_state == AISF_CAL_IDLE),
    .value(scaled),
    .overshoot(scaled_over)
  );

  // Gain that maps the current channel 0 reading to full scale. A reading of
  // zero or less gives unity gain, because a reference must be positive.
  always_comb begin
    if (ch0_std > 0) begin
      cal_gain = GAIN_W'((32'(STD_FULL) << GAIN_FRAC) / 32'(ch0_std));
    end else begin
      cal_gain = GAIN_ONE;
    end
  end

  // ==========================================================================
  // Next-state logic.
  // ==========================================================================
  always_comb begin
    next_st = st;
    if (clk_en) begin
      // The first stage is only read by the second.
      next_st.strap_sync = {st.strap_sync[1:0], connector_presence_strap};
      if (st.strap_sync[2] == st.strap_sync[1]) begin
        next_st.strap_present = st.strap_sync[2];
      end
      // Flash timebase for the terminal-block lamp.
      if (st.flash_cnt >= FW'(FLASH_CYC - 1)) begin
        next_st.flash_cnt = '0;
        next_st.flash = !st.flash;
      end else begin
        next_st.flash_cnt = st.flash_cnt + FW'(1);
      end
      // Alignment access; the host keeps offsets within the legal band.
      if (align_write) begin
        next_st.offset[align_chan] = align_wdata;
        next_st.aligned[align_chan] = 1'b1;
      end else if (align_clear) begin
        next_st.aligned[align_chan] = 1'b0;
      end
      next_st.align_rd = st.offset[align_chan];
      // Recalibration sequencer.
      case (st.cal_state)
        AISF_CAL_IDLE: begin
          if (recal_enter) begin
            next_st.gain_new = st.gain_active;
            next_st.cal_state = AISF_CAL_ACTIVE;
          end
        end
        AISF_CAL_ACTIVE, AISF_CAL_CAPTURED: begin
          // Only channel 0 drives coefficients, and they serve every channel.
          if (sample_valid && sample_chan == '0) begin
            if (recal_ref_10v) begin
              next_st.gain_new[0] = cal_gain;
              next_st.cal_state = AISF_CAL_CAPTURED;
            end else if (recal_ref_5v) begin
              next_st.gain_new[1] = cal_gain;
              next_st.cal_state = AISF_CAL_CAPTURED;
            end
          end
          if (recal_save) begin
            next_st.gain_active = st.gain_new;
            next_st.gain_saved = st.gain_new;
          end
          if (recal_exit) begin
            // Unsaved coefficients are dropped here.
            next_st.cal_state = AISF_CAL_IDLE;
          end
        end
        default: begin
          next_st.cal_state = AISF_CAL_IDLE;
        end
      endcase
      // Factory restore wins over everything else and needs no save.
      if (factory_restore) begin
        next_st.gain_active = {GAIN_ONE, GAIN_ONE};
        next_st.gain_saved = {GAIN_ONE, GAIN_ONE};
        next_st.gain_new = {GAIN_ONE, GAIN_ONE};
      end
      // Channel value update; frozen on communication failure.
      if (sample_valid && !comm_fail) begin
        if (st.cal_state == AISF_CAL_IDLE || sample_chan == '0) begin
          next_st.value[sample_chan] = scaled;
          next_st.over[sample_chan] = scaled_over;
        end
      end
    end
  end

  // Registers the whole state; reset loads factory gains and clears channels.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
      st.cal_state <= AISF_CAL_IDLE;
      st.gain_active <= {GAIN_ONE, GAIN_ONE};
      st.gain_saved <= {GAIN_ONE, GAIN_ONE};
      st.gain_new <= {GAIN_ONE, GAIN_ONE};
      st.strap_present <= 1'b1;
      st.strap_sync <= 3'h7;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs.
  // ==========================================================================
  assign terminal_fault = terminal_monitor_en && (|chan_used) && !st.strap_present;
  assign any_over = |(st.over & chan_used);
  assign internal_fault = selftest_ref_fail;
  assign recal_active = st.cal_state != AISF_CAL_IDLE;
  // Filtering is allowed only in normal cycle and outside recalibration.
  assign filter_active = filter_request && !fast_cycle && !recal_active;
  assign chan_aligned = st.aligned;
  assign align_rdata = st.align_rd;

  // Per-channel presentation of value, fault and status.
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      logic ch_over; // Overshoot reported for this channel.
      logic ch_term; // Connector fault reported for this channel.
      assign ch_over = st.over[g] && chan_used[g];
      assign ch_term = terminal_fault && chan_used[g];
      // Any self-test failure forces the value to zero.
      assign chan_value[VAL_W*g +: VAL_W] =
        (selftest_ref_fail || selftest_other_fail) ? '0 : st.value[g];
      assign chan_fault[g] = ch_over || ch_term || recal_active;
      assign chan_status[STATUS_W*g +: STATUS_W] =
        {1'b0, ch_term, ch_over, 1'b0};
    end
  endgenerate

  // Lamps: error steady on any self-test failure; I/O steady on overshoot,
  // flashing on connector fault alone.
  assign lamp_run = !(selftest_ref_fail || selftest_other_fail) || !comm_fail;
  assign lamp_err = selftest_ref_fail || selftest_other_fail;
  assign lamp_io = any_over || (terminal_fault && st.flash);
endmodule

//--- testbench/aisf_checker.sv
// Concurrent checks on the ports of the analog input post-processing block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ns
module aisf_checker
  import aisf_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic fast_cycle,
  input wire logic filter_request,
  input wire logic recal_enter,
  input wire logic recal_exit,
  input wire logic selftest_ref_fail,
  input wire logic selftest_other_fail,
  input wire logic comm_fail,
  input wire logic [VAL_W*CHANNELS-1:0] chan_value,
  input wire logic [CHANNELS-1:0] chan_fault,
  input wire logic [STATUS_W*CHANNELS-1:0] chan_status,
  input wire logic internal_fault,
  input wire logic filter_active,
  input wire logic recal_active,
  input wire logic lamp_err,
  input wire logic lamp_io
);
  // ====================
  // Helper logic
  // ====================
  // Status bits gathered per channel, so one check covers every channel.
  logic [CHANNELS-1:0] ov_bits;
  logic [CHANNELS-1:0] conn_bits;
  logic st_any;
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      ov_bits[i] = chan_status[i*STATUS_W+STATUS_OVERSHOOT_POS];
      conn_bits[i] = chan_status[i*STATUS_W+STATUS_TERMINAL_POS];
    end
  end
  assign st_any = selftest_ref_fail | selftest_other_fail;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // A lone enter or exit pulse on an enabled edge; both at once is left open.
  sequence s_enter;
    recal_enter && clk_en && !recal_exit;
  endsequence
  sequence s_exit;
    recal_exit && clk_en && !recal_enter;
  endsequence
  chk_recal_enter: assert property (s_enter |=> recal_active)
    else $error("recalibration mode not entered");
  chk_recal_leave: assert property (s_exit |=> !recal_active)
    else $error("recalibration mode not left");
  chk_recal_faults: assert property (recal_active |-> &chan_fault)
    else $error("channel fault low during recalibration");
  chk_filter_gate: assert property (
    filter_active == (filter_request && !fast_cycle && !recal_active))
    else $error("filter enable wrong");
  chk_selftest_zero: assert property (st_any |-> chan_value == '0 && lamp_err)
    else $error("self-test failure not shown");
  chk_internal_report: assert property (internal_fault == selftest_ref_fail)
    else $error("internal fault report wrong");
  // The freeze holds only across edges with no reset and no forced zero.
  chk_comm_freeze: assert property (
    $past(comm_fail) && $past(rst_n) && !st_any && !$past(st_any) |-> $stable(chan_value))
    else $error("channel value moved during communication fault");
  chk_over_fault: assert property (((ov_bits | conn_bits) & ~chan_fault) == '0)
    else $error("status bit without channel fault");
  // Checked on every cycle of the fault, which is what steady means; an
  // overshoot may clear after one sample, so no fixed run length is asked.
  chk_over_lamp: assert property (|ov_bits |-> lamp_io)
    else $error("lamp not steady on overshoot");
endmodule
bind aisf_top aisf_checker #(.CHANNELS(CHANNELS)) i_chk (.clk_sys, .rst_n, .clk_en, .fast_cycle,
  .filter_request, .recal_enter, .recal_exit, .selftest_ref_fail, .selftest_other_fail,
  .comm_fail, .chan_value, .chan_fault, .chan_status, .internal_fault, .filter_active,
  .recal_active, .lamp_err, .lamp_io);

//--- testbench/aisf_host.sv
// Model of the controller processor that writes offsets and owns the link.
// Assumes requests from the bench arrive on the system clock.
`timescale 1ns/1ns
module aisf_host
  import aisf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic align_req,
  input wire logic signed [VAL_W-1:0] align_val,
  input wire logic link_down,
  output logic signed [VAL_W-1:0] align_wdata,
  output logic align_write,
  output logic comm_fail
);
  // ====================
  // Request register
  // ====================
  // Offsets are clipped here so the block never sees an out-of-band one.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      align_write <= 1'b0;
      align_wdata <= 16'h0000;
      comm_fail <= 1'b0;
    end else begin
      align_write <= align_req;
      comm_fail <= link_down;
      if (align_val > ALIGN_LIMIT) begin
        align_wdata <= 16'h03E8;
      end else if (align_val < -ALIGN_LIMIT) begin
        align_wdata <= 16'hFC18;
      end else begin
        align_wdata <= align_val;
      end
    end
  end
endmodule

//--- testbench/aisf_top_tb.sv
// Self-checking bench for the analog input post-processing block.
// Assumes the host model and the checker are compiled before this file.
`timescale 1ns/1ns
module aisf_top_tb;
  import aisf_pkg::*;
  // ====================
  // Stimulus and wiring
  // ====================
  logic clk_sys = 1'b0, rst_n = 1'b0, clk_en = 1'b1, s_valid = 1'b0, user_fmt = 1'b0;
  logic [2:0] s_chan = 3'h0, align_chan = 3'h2;
  logic signed [15:0] s_raw = 16'h0000, user_low = 16'h0000, user_high = 16'h2710;
  logic signed [15:0] a_val = 16'h000A, align_wdata, align_rdata;
  logic [23:0] range_sel = 24'h000000;
  logic [7:0] chan_used = 8'hFF, chan_fault, chan_aligned;
  logic [4:0] pl = 5'h00;
  logic fast_cycle = 1'b0, filter_request = 1'b1, a_req = 1'b0, link_down = 1'b0;
  logic ref10 = 1'b0, ref5 = 1'b0, tmon = 1'b0, strap = 1'b1, st_ref = 1'b0, st_oth = 1'b0;
  logic align_write, comm_fail, internal_fault, filter_active, recal_active;
  logic lamp_run, lamp_err, lamp_io, hi, lo;
  logic [127:0] chan_value;
  logic [31:0] chan_status;
  int failures = 0, compares = 0;
  // Free-running 100 ns clock.
  always #50 clk_sys = ~clk_sys;
  aisf_host i_host (.clk_sys, .rst_n, .align_req(a_req), .align_val(a_val), .link_down,
    .align_wdata, .align_write, .comm_fail);
  // Lamp half period shortened to four cycles so flashing shows quickly.
  aisf_top #(.CHANNELS(8), .FLASH_CYC(4)) i_dut (.clk_sys, .rst_n, .clk_en,
    .sample_chan(s_chan), .sample_raw(s_raw), .sample_valid(s_valid), .range_sel, .chan_used,
    .user_fmt, .user_low, .user_high, .fast_cycle, .filter_request, .align_chan, .align_wdata,
    .align_write, .align_clear(pl[4]), .recal_enter(pl[0]), .recal_exit(pl[1]),
    .recal_ref_10v(ref10), .recal_ref_5v(ref5), .recal_save(pl[2]), .factory_restore(pl[3]),
    .terminal_monitor_en(tmon), .connector_presence_strap(strap), .selftest_ref_fail(st_ref),
    .selftest_other_fail(st_oth), .comm_fail, .chan_value, .chan_fault, .chan_status,
    .chan_aligned, .align_rdata, .internal_fault, .filter_active, .recal_active, .lamp_run,
    .lamp_err, .lamp_io);
  // ====================
  // Shared tasks
  // ====================
  // Counts every comparison; an unknown never matches.
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
    end
  endtask
  function automatic logic [15:0] v(input int c);
    return chan_value[c*16+:16];
  endfunction
  // One raw sample; the value is looked at once the next edge has landed.
  task automatic samp(input logic [2:0] c, input logic [15:0] r);
    @(posedge clk_sys);
    s_chan <= c;
    s_raw <= r;
    s_valid <= 1'b1;
    @(posedge clk_sys);
    s_valid <= 1'b0;
    @(negedge clk_sys);
  endtask
  // One-cycle pulse: 0 enter, 1 exit, 2 save, 3 factory, 4 align clear.
  task automatic pulse(input int k);
    @(posedge clk_sys);
    pl <= 5'h01 << k;
    @(posedge clk_sys);
    pl <= 5'h00;
    repeat (2) @(negedge clk_sys);
  endtask
  // Watches the lamp for three half periods and notes both levels seen.
  task automatic lamp_seen();
    hi = 1'b0;
    lo = 1'b0;
    repeat (12) begin
      @(negedge clk_sys);
      hi = hi | (lamp_io === 1'b1);
      lo = lo | (lamp_io === 1'b0);
    end
  endtask
  // ====================
  // Scenarios
  // ====================
  task automatic t_scale();
    range_sel <= 24'h000040;
    samp(3'h2, 16'h0C80);
    chk("ch2 std", 16'h0C80, v(2));
    samp(3'h0, 16'hD8F0);
    chk("ch0 bipolar", 16'hD8F0, v(0));
    user_fmt <= 1'b1;
    user_high <= 16'h2580;
    user_low <= 16'h0C80;
    samp(3'h2, 16'h1388);
    chk("ch2 user mid", 16'h1900, v(2));
    samp(3'h2, 16'h0001);
    chk("ch2 user round", 16'h0C81, v(2));
    user_high <= 16'h7D00;
    user_low <= 16'h8300;
    samp(3'h2, 16'h2710);
    chk("ch2 user high", 16'h7530, v(2));
    samp(3'h2, 16'h0000);
    chk("ch2 user low", 16'h8AD0, v(2));
    user_fmt <= 1'b0;
    $display("test t_scale done");
  endtask
  task automatic t_align();
    @(posedge clk_sys);
    a_req <= 1'b1;
    @(posedge clk_sys);
    a_req <= 1'b0;
    samp(3'h2, 16'h0C80);
    chk("ch2 aligned", 16'h0C8A, v(2));
    chk("offset read", 16'h000A, align_rdata);
    chk("aligned flag", 16'h0001, {15'h0000, chan_aligned[2]});
    pulse(4);
    samp(3'h2, 16'h0C80);
    chk("ch2 unaligned", 16'h0C80, v(2));
    chk("flag cleared", 16'h0000, {15'h0000, chan_aligned[2]});
    $display("test t_align done");
  endtask
  task automatic t_faults();
    range_sel <= 24'h000050;
    samp(3'h2, 16'h2904);
    chk("edge no over", 16'h0000, {15'h0000, chan_status[9]});
    samp(3'h1, 16'hFFFF);
    chk("ch1 negative", 16'h0001, {15'h0000, chan_status[5]});
    samp(3'h1, 16'h0000);
    tmon <= 1'b1;
    strap <= 1'b0;
    // Let the strap clear the synchroniser so the dark level is seen while flashing.
    repeat (4) @(negedge clk_sys);
    lamp_seen();
    chk("conn bit", 16'h0001, {15'h0000, chan_status[10] & chan_fault[2]});
    chk("lamp flashing", 16'h0003, {14'h0000, hi, lo});
    samp(3'h2, 16'h2968);
    lamp_seen();
    chk("over bit", 16'h0001, {15'h0000, chan_status[9] & chan_fault[2]});
    chk("lamp steady", 16'h0002, {14'h0000, hi, lo});
    samp(3'h2, 16'h0C80);
    tmon <= 1'b0;
    strap <= 1'b1;
    $display("test t_faults done");
  endtask
  task automatic t_recal();
    pulse(0);
    chk("all faults", 16'h00FF, {8'h00, chan_fault});
    chk("filter off", 16'h0000, {15'h0000, filter_active});
    samp(3'h2, 16'h1388);
    chk("ch2 held", 16'h0C80, v(2));
    ref10 <= 1'b1;
    samp(3'h0, 16'h2328);
    pulse(1);
    samp(3'h0, 16'h2328);
    chk("unsaved dropped", 16'h2328, v(0));
    pulse(0);
    samp(3'h0, 16'h2328);
    pulse(2);
    pulse(1);
    ref10 <= 1'b0;
    samp(3'h0, 16'h2328);
    chk("ch0 gain", 16'h0001, {15'h0000, v(0) >= 16'h2706 && v(0) <= 16'h271A});
    samp(3'h2, 16'h2328);
    chk("ch2 gain", 16'h0001, {15'h0000, v(2) >= 16'h2706 && v(2) <= 16'h271A});
    samp(3'h1, 16'h0FA0);
    chk("5V group kept", 16'h0FA0, v(1));
    pulse(3);
    samp(3'h0, 16'h2328);
    chk("factory back", 16'h2328, v(0));
    $display("test t_recal done");
  endtask
  task automatic t_other();
    fast_cycle <= 1'b1;
    @(negedge clk_sys);
    chk("fast no filter", 16'h0000, {15'h0000, filter_active});
    fast_cycle <= 1'b0;
    st_oth <= 1'b1;
    samp(3'h2, 16'h0C80);
    chk("zeroed", 16'h0000, v(2));
    chk("err lamp", 16'h0001, {15'h0000, lamp_err});
    chk("run lamp", 16'h0001, {15'h0000, lamp_run});
    chk("not reported", 16'h0000, {15'h0000, internal_fault});
    st_oth <= 1'b0;
    st_ref <= 1'b1;
    @(negedge clk_sys);
    chk("ref reported", 16'h0001, {15'h0000, internal_fault});
    st_ref <= 1'b0;
    link_down <= 1'b1;
    repeat (2) @(posedge clk_sys);
    samp(3'h2, 16'h1388);
    chk("frozen", 16'h0C80, v(2));
    link_down <= 1'b0;
    $display("test t_other done");
  endtask
  // ====================
  // Run and verdict
  // ====================
  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // The tests need well under a thousand cycles; twenty thousand means a hang.
  initial begin
    #2000000;
    failures++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_scale();
    t_align();
    t_faults();
    t_recal();
    t_other();
    final_report();
  end
endmodule
